// *** include/wdog_map.svh ***
`ifndef WDOG_MAP_SVH
`define WDOG_MAP_SVH

// Clock period of mclk_i in ns
`define WDOG_CLK_PERIOD_NS 10

// Reset pin pull-down after a failed refresh, in ns and in cycles
`define WDOG_ERR_RESET_TIME_NS 1000000
`define WDOG_ERR_RESET_CYC ((`WDOG_ERR_RESET_TIME_NS) / (`WDOG_CLK_PERIOD_NS))

// Default window limits and power-on delay, in cycles
`define WDOG_MIN_WIN_CYC 1000
`define WDOG_MAX_WIN_CYC 4000
`define WDOG_POR_DELAY_CYC 2000

// Counter widths
`define WDOG_WIN_CNT_W 16
`define WDOG_POR_CNT_W 16
`define WDOG_PULSE_CNT_W 17

// Reset values
`define WDOG_FLAG_RST 1'b0
`define WDOG_LOCKOUT_RST 1'b0
`define WDOG_POL_RST 1'b0

`endif

// *** include/wdog_pkg.sv ***
package wdog_pkg;

	// Refresh state machine states, one-hot
	typedef enum logic [3:0] {
		ST_INITIAL = 4'h1,
		ST_DRIVE = 4'h2,
		ST_TEST = 4'h4,
		ST_OVERRIDE = 4'h8
	} refresh_state_e;

	// Reset sources seen by the block, each high when faulty
	typedef struct packed {
		logic vcc_fault;
		logic vdd_fault;
		logic analog_ground_fault;
		logic bandgap_fault;
	} monitor_s;

	// Arm and safe output pins with their enables
	typedef struct packed {
		logic arm;
		logic arm_oe;
		logic safe_output;
		logic safe_output_oe;
	} arm_pins_s;

	// Internal reset lines distributed by the block
	typedef struct packed {
		logic core_block_reset;
		logic refresh_fsm_reset;
		logic safing_fsm_reset;
		logic analog_fail_reset;
		logic sleep_logic_reset;
	} resets_s;

endpackage

// *** src/interval_timer.sv ***
`timescale 1ns/10ps
`default_nettype none

// Saturating up-counter cleared by a pulse
module interval_timer #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic clr_i,
	// Count
	output logic [W-1:0] count_o
);

	logic [W-1:0] count_d;

	// Next count: clear, hold at the top, or step
	always_comb
	begin
		if (clr_i)
			count_d = '0;
		else if (&count_o)
			count_d = count_o;
		else
			count_d = count_o + W'(1);
	end

	// Count register
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			count_o <= '0;
		else
			count_o <= count_d;
	end

endmodule

`default_nettype wire

// *** src/window_watchdog_reset_arming.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "wdog_map.svh"

module window_watchdog_reset_arming #(
	parameter int MIN_WIN_CYC = `WDOG_MIN_WIN_CYC,
	parameter int MAX_WIN_CYC = `WDOG_MAX_WIN_CYC,
	parameter int POR_DELAY_CYC = `WDOG_POR_DELAY_CYC,
	parameter int ERR_RESET_CYC = `WDOG_ERR_RESET_CYC
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic arst_n_i,
	// Supply, ground and bandgap monitors, analog fail, sleep and safing reset requests
	input wire wdog_pkg::monitor_s monitor_i,
	input wire logic analog_fail_i,
	input wire logic sleep_request_i,
	input wire logic safing_reset_request_i,
	// Decoded serial commands, one-cycle pulses
	input wire logic refresh_command_i,
	input wire logic refresh_polarity_i,
	input wire logic lockout_suppress_command_i,
	input wire logic override_command_i,
	// Internal arm control
	input wire logic arm_request_i,
	input wire logic safe_request_i,
	// External reset pin and internal resets
	output logic reset_pin_n_o,
	output wdog_pkg::resets_s resets_o,
	// Arming pins
	output wdog_pkg::arm_pins_s pins_o,
	// Status
	output logic watchdog_error_flag_o,
	output logic arm_lockout_o,
	output wdog_pkg::refresh_state_e state_o
);

	localparam int WW = `WDOG_WIN_CNT_W;
	localparam int PW = `WDOG_POR_CNT_W;
	localparam int EW = `WDOG_PULSE_CNT_W;

	// Reset release through two flip-flops
	logic rst_meta_q;
	logic rst_n;

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// Resets derived from the monitors
	logic internal_reset;
	logic supply_hold;
	logic por_done;
	logic por_clr;
	logic [PW-1:0] por_count;

	assign internal_reset = monitor_i.vdd_fault | monitor_i.bandgap_fault;
	assign por_clr = monitor_i.vcc_fault | internal_reset;
	assign por_done = (por_count >= PW'(POR_DELAY_CYC));
	assign supply_hold = por_clr | ~por_done;

	// Power-on delay runs only while the supply stays valid
	interval_timer #(
		.W(PW)
	) u_por_timer (
		.clk_i(mclk_i),
		.rst_n_i(rst_n),
		.clr_i(por_clr),
		.count_o(por_count)
	);

	// Refresh window timer, restarted on every refresh
	logic [WW-1:0] win_count;
	logic win_clr;

	interval_timer #(
		.W(WW)
	) u_win_timer (
		.clk_i(mclk_i),
		.rst_n_i(rst_n),
		.clr_i(win_clr),
		.count_o(win_count)
	);

	// Pull-down timer for a watchdog reset pulse
	logic [EW-1:0] pulse_count;
	logic pulse_clr;

	interval_timer #(
		.W(EW)
	) u_pulse_timer (
		.clk_i(mclk_i),
		.rst_n_i(rst_n),
		.clr_i(pulse_clr),
		.count_o(pulse_count)
	);

	// Refresh state machine
	wdog_pkg::refresh_state_e state_q, state_d;
	logic flag_q, flag_d;
	logic lockout_q, lockout_d;
	logic pol_q, pol_d;
	logic pulse_q, pulse_d;
	logic fsm_reset;
	logic in_window;
	logic refresh_ok;
	logic wd_error;
	logic timeout;
	logic timed;

	// Machine reset comes from the supply ramp and internal reset
	assign fsm_reset = supply_hold;
	assign timed = (state_q == wdog_pkg::ST_DRIVE) || (state_q == wdog_pkg::ST_TEST);
	assign in_window = (win_count >= WW'(MIN_WIN_CYC)) && (win_count <= WW'(MAX_WIN_CYC));
	// Opposite polarity inside the window
	assign refresh_ok = refresh_command_i && (refresh_polarity_i != pol_q) && in_window;
	// Late refresh also caught when none arrives at all
	assign timeout = timed && (win_count > WW'(MAX_WIN_CYC));
	assign wd_error = timed && ((refresh_command_i && !refresh_ok) || timeout);

	always_comb
	begin
		state_d = state_q;
		flag_d = flag_q;
		lockout_d = lockout_q;
		pol_d = pol_q;
		pulse_d = pulse_q;
		win_clr = 1'b0;
		pulse_clr = 1'b0;
		// Pull-down ends after its fixed length
		if (pulse_q && (pulse_count >= EW'(ERR_RESET_CYC - 1)))
			pulse_d = 1'b0;
		if (fsm_reset)
		begin
			state_d = wdog_pkg::ST_INITIAL;
			flag_d = `WDOG_FLAG_RST;
			lockout_d = `WDOG_LOCKOUT_RST;
			pol_d = `WDOG_POL_RST;
			pulse_d = 1'b0;
			win_clr = 1'b1;
		end
		else
		begin
			case (state_q)
				wdog_pkg::ST_INITIAL:
				begin
					win_clr = 1'b1;
					if (refresh_command_i)
					begin
						// First refresh is a successful one
						state_d = wdog_pkg::ST_DRIVE;
						flag_d = 1'b0;
						pol_d = refresh_polarity_i;
					end
					// Override only straight after a machine reset, never after an error
					else if (override_command_i && !flag_q && !lockout_q)
						state_d = wdog_pkg::ST_OVERRIDE;
				end
				wdog_pkg::ST_DRIVE, wdog_pkg::ST_TEST:
				begin
					if (wd_error)
					begin
						flag_d = 1'b1;
						pulse_d = 1'b1;
						pulse_clr = 1'b1;
						if (state_q == wdog_pkg::ST_DRIVE)
							lockout_d = 1'b1;
						state_d = wdog_pkg::ST_INITIAL;
					end
					else if (refresh_ok)
					begin
						flag_d = 1'b0;
						pol_d = refresh_polarity_i;
						win_clr = 1'b1;
						// Suppression lapses once its window closes
						state_d = lockout_suppress_command_i ? wdog_pkg::ST_TEST
							: wdog_pkg::ST_DRIVE;
					end
					else if (lockout_suppress_command_i)
						state_d = wdog_pkg::ST_TEST;
				end
				wdog_pkg::ST_OVERRIDE:
				begin
					// No errors in override; polarity still tracked
					if (refresh_command_i)
					begin
						pol_d = refresh_polarity_i;
						win_clr = 1'b1;
					end
				end
				default:
					state_d = wdog_pkg::ST_INITIAL;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= wdog_pkg::ST_INITIAL;
			flag_q <= `WDOG_FLAG_RST;
			lockout_q <= `WDOG_LOCKOUT_RST;
			pol_q <= `WDOG_POL_RST;
			pulse_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			flag_q <= flag_d;
			lockout_q <= lockout_d;
			pol_q <= pol_d;
			pulse_q <= pulse_d;
		end
	end

	// Reset pin, internal resets and arming pins
	logic reset_pin_n_d;
	logic system_reset;
	logic pass;
	wdog_pkg::resets_s resets_d;
	wdog_pkg::arm_pins_s pins_d;

	always_comb
	begin
		// Any monitor fault, the supply hold or an error pulse pulls the reset pin low
		system_reset = supply_hold | monitor_i.vcc_fault | monitor_i.vdd_fault
			| monitor_i.analog_ground_fault | monitor_i.bandgap_fault | pulse_q;
		reset_pin_n_d = ~system_reset;
		resets_d.core_block_reset = internal_reset | supply_hold;
		resets_d.refresh_fsm_reset = fsm_reset;
		resets_d.safing_fsm_reset = safing_reset_request_i | supply_hold;
		resets_d.analog_fail_reset = analog_fail_i;
		resets_d.sleep_logic_reset = sleep_request_i;
		// Arm passes only in override or in a clean drive state
		pass = (state_q == wdog_pkg::ST_OVERRIDE)
			|| ((state_q == wdog_pkg::ST_DRIVE) && !resets_o.safing_fsm_reset
			&& !lockout_q);
		// A system reset blocks the pins in every state, override included
		if (system_reset)
			pass = 1'b0;
		if (analog_fail_i)
			pass = 1'b0;
		pins_d.arm = pass & arm_request_i;
		pins_d.safe_output = pass & safe_request_i;
		pins_d.arm_oe = pass;
		pins_d.safe_output_oe = pass;
	end

	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reset_pin_n_o <= 1'b0;
			resets_o <= '1;
			pins_o <= '0;
		end
		else
		begin
			reset_pin_n_o <= reset_pin_n_d;
			resets_o <= resets_d;
			pins_o <= pins_d;
		end
	end

	// Status outputs straight from registers
	assign watchdog_error_flag_o = flag_q;
	assign arm_lockout_o = lockout_q;
	assign state_o = state_q;

endmodule

`default_nettype wire

// *** verification/wdog_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module wdog_props #(
	parameter int MIN_WIN_CYC = 10,
	parameter int MAX_WIN_CYC = 40,
	parameter int ERR_RESET_CYC = 50
) (
	// Clock, reset and causes
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire wdog_pkg::monitor_s monitor_i,
	input wire logic analog_fail_i,
	input wire logic safing_reset_request_i,
	input wire logic refresh_command_i,
	input wire logic refresh_polarity_i,
	input wire logic arm_request_i,
	// Watched outputs
	input wire logic reset_pin_n_o,
	input wire wdog_pkg::arm_pins_s pins_o,
	input wire logic watchdog_error_flag_o,
	input wire logic arm_lockout_o,
	input wire wdog_pkg::refresh_state_e state_o
);
	logic [15:0] win_q, win_d, low_q, low_d;
	logic pol_q, pol_d;
	wire logic drv = state_o == wdog_pkg::ST_DRIVE;
	wire logic hiz = !pins_o.arm_oe && !pins_o.safe_output_oe;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);
	// Cycles since a refresh, its polarity, cycles of reset pin low
	always_comb
	begin
		win_d = refresh_command_i ? 16'h0000 : win_q + 16'h0001;
		pol_d = refresh_command_i ? refresh_polarity_i : pol_q;
		low_d = reset_pin_n_o ? 16'h0000 : low_q + 16'h0001;
	end
	// Helper registers
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			win_q <= 16'h0000;
			pol_q <= 1'b0;
			low_q <= 16'h0000;
		end
		else
		begin
			win_q <= win_d;
			pol_q <= pol_d;
			low_q <= low_d;
		end
	end
	// Drive state with nothing blocking the outputs
	sequence s_clean;
		(drv && !arm_lockout_o && !safing_reset_request_i && !analog_fail_i && reset_pin_n_o
			&& $stable(arm_request_i))[*3];
	endsequence
	chk_src_pin_low: assert property (|monitor_i |-> ##[1:3] !reset_pin_n_o)
		else $error("reset pin not low on monitor fault");
	chk_ramp_hold: assert property (monitor_i.vcc_fault[*4] |->
		state_o == wdog_pkg::ST_INITIAL && !watchdog_error_flag_o && !reset_pin_n_o)
		else $error("supply ramp not holding");
	chk_first_feed: assert property (state_o == wdog_pkg::ST_INITIAL && refresh_command_i
		&& reset_pin_n_o |=> drv && !watchdog_error_flag_o)
		else $error("first refresh not taken");
	chk_init_hiz: assert property ((state_o == wdog_pkg::ST_INITIAL)[*2] |-> hiz)
		else $error("outputs driven before first refresh");
	chk_early_err: assert property (drv && refresh_command_i && win_q < MIN_WIN_CYC - 2
		|=> watchdog_error_flag_o)
		else $error("early refresh not flagged");
	chk_late_err: assert property (drv |-> win_q < MAX_WIN_CYC + 4)
		else $error("missing refresh not flagged");
	chk_good_feed: assert property (drv && refresh_command_i && refresh_polarity_i != pol_q
		&& win_q > MIN_WIN_CYC + 2 && win_q < MAX_WIN_CYC - 2
		|=> drv && !watchdog_error_flag_o)
		else $error("correct refresh refused");
	chk_err_pulse: assert property ($rose(reset_pin_n_o) && watchdog_error_flag_o
		|-> low_q >= ERR_RESET_CYC - 1 && low_q <= ERR_RESET_CYC + 3)
		else $error("error reset pulse length wrong");
	chk_lock_hiz: assert property (arm_lockout_o[*2] |-> hiz)
		else $error("outputs driven under lockout");
	chk_lock_src: assert property ($rose(arm_lockout_o)
		|-> $past(state_o) == wdog_pkg::ST_DRIVE)
		else $error("lockout from wrong state");
	chk_arm_pass: assert property (s_clean |-> pins_o.arm_oe
		&& pins_o.arm == arm_request_i)
		else $error("arm not passed in drive");
	chk_afail_hiz: assert property (analog_fail_i[*3] |-> hiz)
		else $error("outputs driven on analog fail");
endmodule
bind window_watchdog_reset_arming wdog_props #(.MIN_WIN_CYC(MIN_WIN_CYC),
	.MAX_WIN_CYC(MAX_WIN_CYC), .ERR_RESET_CYC(ERR_RESET_CYC)) wdog_props_inst (.*);
`default_nettype wire

// *** verification/mcu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Controller side issuing decoded command pulses
module mcu_model (
	// Clock
	input wire logic mclk_i,
	// Command pulses
	output logic refresh_command_o,
	output logic refresh_polarity_o,
	output logic lockout_suppress_command_o,
	output logic override_command_o
);
	// Idle levels
	initial
	begin
		refresh_command_o = 1'b0;
		refresh_polarity_o = 1'b0;
		lockout_suppress_command_o = 1'b0;
		override_command_o = 1'b0;
	end
	// One-cycle pulse: 0 refresh, 1 suppress, 2 override
	task automatic pulse(input logic [1:0] kind, input logic pol);
		@(negedge mclk_i);
		refresh_polarity_o = pol;
		refresh_command_o = kind == 2'h0;
		lockout_suppress_command_o = kind == 2'h1;
		override_command_o = kind == 2'h2;
		@(negedge mclk_i);
		refresh_command_o = 1'b0;
		lockout_suppress_command_o = 1'b0;
		override_command_o = 1'b0;
		refresh_polarity_o = ~pol;
	endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
	localparam int POR = 20;
	localparam int ERR = 50;
	logic mclk_i = 1'b0;
	logic arst_n_i = 1'b0;
	wdog_pkg::monitor_s monitor_i = 4'h0;
	logic analog_fail_i = 1'b0;
	logic sleep_request_i = 1'b0;
	logic safing_reset_request_i = 1'b0;
	logic arm_request_i = 1'b1;
	logic safe_request_i = 1'b0;
	logic refresh_command_i, refresh_polarity_i, lockout_suppress_command_i, override_command_i;
	logic reset_pin_n_o, watchdog_error_flag_o, arm_lockout_o;
	wdog_pkg::resets_s resets_o;
	wdog_pkg::arm_pins_s pins_o;
	wdog_pkg::refresh_state_e state_o;
	wire logic [1:0] oe = {pins_o.arm_oe, pins_o.safe_output_oe};
	wire logic [5:0] fs = {arm_lockout_o, watchdog_error_flag_o, state_o};
	int err_total = 0;
	int total_checks = 0;
	// Clock
	always #5 mclk_i = ~mclk_i;
	// Controller model and block
	mcu_model mcu_model_inst (.mclk_i(mclk_i), .refresh_command_o(refresh_command_i),
		.refresh_polarity_o(refresh_polarity_i),
		.lockout_suppress_command_o(lockout_suppress_command_i),
		.override_command_o(override_command_i));
	window_watchdog_reset_arming #(.MIN_WIN_CYC(10), .MAX_WIN_CYC(40), .POR_DELAY_CYC(POR),
		.ERR_RESET_CYC(ERR)) window_watchdog_reset_arming_inst (.*);
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task automatic ck(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic feed(input logic p);
		mcu_model_inst.pulse(2'h0, p);
	endtask
	task automatic end_of_test;
		$display("mismatches %0d of %0d checks", err_total, total_checks);
		if (err_total == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Power-on hold, then every reset source
	task automatic t_src;
		ck(fs, 8'h01);
		cyc(POR + 6);
		ck({reset_pin_n_o, oe}, 8'h4);
		{analog_fail_i, sleep_request_i, safing_reset_request_i} = 3'h7;
		cyc(3);
		ck({resets_o.analog_fail_reset, resets_o.sleep_logic_reset,
			resets_o.safing_fsm_reset}, 8'h7);
		{analog_fail_i, sleep_request_i, safing_reset_request_i} = 3'h0;
		for (int i = 0; i < 4; i++)
		begin
			monitor_i = 4'h1 << i;
			cyc(4);
			ck({reset_pin_n_o, resets_o.core_block_reset}, {1'b0, i != 1});
			monitor_i = 4'h0;
			cyc(POR + 8);
		end
	endtask
	// First refresh, arming gates, correct refresh
	task automatic t_drive;
		feed(1'b1);
		ck(fs, 8'h02);
		cyc(2);
		ck(pins_o, 8'hD);
		safing_reset_request_i = 1'b1;
		cyc(3);
		ck(oe, 8'h0);
		safing_reset_request_i = 1'b0;
		analog_fail_i = 1'b1;
		cyc(3);
		ck(oe, 8'h0);
		analog_fail_i = 1'b0;
		cyc(12);
		feed(1'b0);
		ck(fs, 8'h02);
	endtask
	// Suppressed lockout, then error pulse length
	task automatic t_test;
		cyc(5);
		mcu_model_inst.pulse(2'h1, 1'b0);
		ck(fs, 8'h04);
		cyc(2);
		ck(oe, 8'h0);
		cyc(13);
		feed(1'b0);
		ck(fs, 8'h11);
		cyc(ERR - 2);
		ck(reset_pin_n_o, 8'h0);
		cyc(8);
		ck(reset_pin_n_o, 8'h1);
	endtask
	// Flag cleared, early and missing refresh with lockout
	task automatic t_lock;
		feed(1'b1);
		ck(fs, 8'h02);
		cyc(2);
		feed(1'b0);
		ck(fs, 8'h31);
		cyc(ERR + 8);
		feed(1'b1);
		cyc(2);
		ck({fs, oe}, 8'h88);
		cyc(50);
		ck(fs, 8'h31);
	endtask
	// Machine reset, override with both outputs driven
	task automatic t_ovr;
		monitor_i.vcc_fault = 1'b1;
		cyc(4);
		ck({resets_o.refresh_fsm_reset, resets_o.safing_fsm_reset}, 8'h3);
		monitor_i.vcc_fault = 1'b0;
		cyc(POR + 6);
		ck(fs, 8'h01);
		ck(resets_o, 8'h0);
		mcu_model_inst.pulse(2'h2, 1'b0);
		ck(fs, 8'h08);
		safe_request_i = 1'b1;
		cyc(3);
		ck(pins_o, 8'hF);
		{arm_request_i, safe_request_i} = 2'h0;
		cyc(3);
		ck(pins_o, 8'h5);
		feed(1'b0);
		feed(1'b0);
		ck(fs, 8'h08);
	endtask
	// Main sequence
	initial
	begin
		cyc(2);
		arst_n_i = 1'b1;
		cyc(1);
		t_src;
		t_drive;
		t_test;
		t_lock;
		t_ovr;
		end_of_test;
	end
	// Watchdog against a hang
	initial
	begin
		#200000;
		err_total++;
		end_of_test;
	end
endmodule
`default_nettype wire
